// *** dv/hbg_fet_model.sv ***
/*
 hbg_fet_model: behavioural power stage as seen by the drain-source comparators.
 Assumes gate commands and the test current enable come from the control block.
*/
`timescale 1ns/1ps
module hbg_fet_model (
   input wire logic [5:0] gate_on,
   input wire logic [5:0] short_on,
   input wire logic gnd_short,
   input wire logic phase1_test_current_enable,
   output logic [5:0] ds_cmp
);
   // a fet conducting into a short shows high drain voltage; a shorted
   // low side sinks the test current and trips its comparator with gates off
   assign ds_cmp = (short_on & gate_on) |
      {5'h00, gnd_short & phase1_test_current_enable};
endmodule

// *** dv/hbg_monitor.sv ***
/*
 hbg_monitor: bus and gate safety assertions on the gate driver control top.
 Assumes it is bound into hbg_bridge_ctrl: one clock, async active-low reset.
*/
`timescale 1ns/1ps
module hbg_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic pump_uv_cmp,
   input wire logic [5:0] gate_on,
   input wire logic [5:0] gate_charging,
   input wire logic [5:0] ds_current_enable,
   input wire logic phase1_test_current_enable
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   // bus kept idle after a trip, so nothing may have re-enabled a driver
   sequence uv_then_idle;
      pump_uv_cmp ##1 (!wb_cyc_i) [*4];
   endsequence
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked in the next cycle");
   a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   a_uv_off: assert property (pump_uv_cmp |=> gate_on == 6'h00)
      else $error("gates on after pump undervoltage");
   a_uv_stays_off: assert property (uv_then_idle |-> gate_on == 6'h00)
      else $error("gates back on without software");
   a_charge_track: assert property (gate_charging == $past(gate_on))
      else $error("slew phase does not follow gate command");
   a_half_bridge_excl: assert property (!(|(gate_on[2:0] & gate_on[5:3])))
      else $error("both fets of one half bridge on");
   a_test_alias: assert property (phase1_test_current_enable == ds_current_enable[3])
      else $error("test current enable differs from its driver bit");
endmodule

bind hbg_bridge_ctrl hbg_monitor u_mon (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
   .pump_uv_cmp, .gate_on, .gate_charging, .ds_current_enable, .phase1_test_current_enable);

// *** dv/testbench.sv ***
/*
 testbench: register-level tests of hbg_bridge_ctrl over wishbone classic.
 Assumes the fet model on ds_cmp and a 100 MHz clk.
*/
`timescale 1ns/1ps
module testbench;
   logic clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic low_power_clock = 1'h0;
   logic [3:0] wsel = 4'hF;
   logic pump_uv_cmp, pump_clk, phase1_test_current_enable, gnd_short;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, pump_undervolt_threshold;
   logic [31:0] wb_dat_i, wb_dat_o, q;
   logic [2:0] compare_out_ch, compare_out_n_ch, drain_source_threshold;
   logic [5:0] ds_cmp, gate_on, gate_charging, ds_current_enable, short_on;
   logic [29:0] gate_current;
   int err_count, checks_done, n, i;
   logic [7:0] ra [5] = '{8'h08, 8'h0C, 8'h10, 8'h18, 8'h20};
   logic [31:0] rv [5] = '{32'h0, 32'h00000F10, 32'h0, 32'h0, 32'h0};
   int so [5] = '{6, 10, 10, 8, 26};
   logic [4:0] sl [5] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h14};
   logic [31:0] dc [4] = '{32'h0, 32'h0A, 32'h1F, 32'h1E};
   int dn [4] = '{4, 16, 0, 256};

   hbg_bridge_ctrl DUT (.clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .compare_out_ch, .compare_out_n_ch, .low_power_clock,
      .ds_cmp, .pump_uv_cmp, .gate_on, .gate_charging, .gate_current, .pump_clk,
      .drain_source_threshold, .pump_undervolt_threshold, .ds_current_enable,
      .phase1_test_current_enable);
   hbg_fet_model u_fet (.gate_on, .short_on, .gnd_short, .phase1_test_current_enable, .ds_cmp);

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      low_power_clock <= ~low_power_clock;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // single classic cycle; read data lands in q
   task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
      int k;
      k = 0;
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_sel_i <= wsel;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk);
         k++;
      end while (wb_ack_o !== 1'h1 && k < 50);
      chk(wb_ack_o, 1'h1);
      q = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk);
   endtask
   task automatic wg(input int g, input logic v);
      n = 0;
      while (gate_on[g] !== v && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk(n < 2000, 1'h1);
   endtask
   // half periods after settling; first few skipped
   task automatic pmeas(input int lo, input int hi);
      int mn, mx, k, c;
      logic p;
      mn = 1000;
      mx = 0;
      for (k = 0; k < 40; k++) begin
         p = pump_clk;
         c = 0;
         while (pump_clk === p && c < 200) begin
            @(posedge clk);
            c++;
         end
         if (k > 5) begin
            mn = (c < mn) ? c : mn;
            mx = (c > mx) ? c : mx;
         end
      end
      chk(mn >= lo && mn <= lo + 2, 1'h1);
      chk(mx >= hi && mx <= hi + 2, 1'h1);
   endtask
   task automatic done_t(input int t);
      $display("test %0d done", t);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      wrap_up();
   end

   initial begin
      {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, pump_uv_cmp, gnd_short} = 6'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      compare_out_ch = 3'h0;
      compare_out_n_ch = 3'h0;
      short_on = 6'h00;
      repeat (12) @(posedge clk);
      rst_b <= 1'h1;
      @(posedge clk);
      for (i = 0; i < 5; i++) begin
         wb(ra[i], 1'h0, 32'h0);
         chk(q, rv[i]);
      end
      wb(8'h20, 1'h1, 32'hFFFFFFFF);
      wb(8'h20, 1'h0, 32'h0);
      chk(q, 32'h0);
      wsel = 4'h2;
      wb(8'h10, 1'h1, 32'hFFFFFFFF);
      wsel = 4'hF;
      wb(8'h10, 1'h0, 32'h0);
      chk(q, 32'h0000FF00);
      done_t(1);
      wb(8'h10, 1'h1, 32'h34535251);
      wb(8'h14, 1'h1, 32'h24232221);
      wb(8'h00, 1'h1, 32'h00000005);
      wg(0, 1'h1);
      for (i = 0; i < 5; i++) begin
         repeat (so[i]) @(posedge clk);
         chk(gate_current[4:0], sl[i]);
      end
      chk(gate_charging[0], 1'h1);
      wb(8'h00, 1'h1, 32'h00000001);
      wg(0, 1'h0);
      repeat (3) @(posedge clk);
      chk(gate_current[4:0], 5'h01);
      chk(gate_charging[0], 1'h0);
      repeat (30) @(posedge clk);
      chk(gate_current[4:0], 5'h04);
      done_t(2);
      for (i = 0; i < 4; i++) begin
         wb(8'h08, 1'h1, dc[i]);
         wb(8'h00, 1'h1, 32'h00000005);
         wg(0, 1'h1);
         wb(8'h00, 1'h1, 32'h00050001);
         wg(0, 1'h0);
         wg(3, 1'h1);
         chk(n + 1 >= dn[i] && n <= dn[i] + 3, 1'h1);
      end
      wb(8'h00, 1'h1, 32'h00010001);
      repeat (300) @(posedge clk);
      wb(8'h00, 1'h1, 32'h00000005);
      wg(0, 1'h1);
      chk(n <= 2, 1'h1);
      wb(8'h00, 1'h1, 32'h0);
      done_t(3);
      wb(8'h08, 1'h1, 32'h0);
      wb(8'h00, 1'h1, 32'h03030303);
      wb(8'h04, 1'h1, 32'h00010003);
      compare_out_ch <= 3'h5;
      compare_out_n_ch <= 3'h2;
      repeat (20) @(posedge clk);
      chk(gate_on, 6'h00);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[17], 1'h0);
      wb(8'h04, 1'h1, 32'h00030003);
      repeat (20) @(posedge clk);
      chk(gate_on, 6'h2A);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[17], 1'h1);
      compare_out_ch <= 3'h2;
      compare_out_n_ch <= 3'h5;
      repeat (20) @(posedge clk);
      chk(gate_on, 6'h15);
      pump_uv_cmp <= 1'h1;
      @(posedge clk);
      pump_uv_cmp <= 1'h0;
      repeat (6) @(posedge clk);
      chk(gate_on, 6'h00);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[16], 1'h1);
      wb(8'h00, 1'h0, 32'h0);
      chk(q, 32'h02020202);
      wb(8'h18, 1'h1, 32'h00010000);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[16], 1'h0);
      chk(gate_on, 6'h00);
      wb(8'h00, 1'h1, 32'h0);
      wb(8'h04, 1'h1, 32'h0);
      done_t(4);
      wb(8'h08, 1'h1, 32'h00014000);
      short_on <= 6'h01;
      wb(8'h04, 1'h1, 32'h00050000);
      wb(8'h00, 1'h1, 32'h00000005);
      wg(0, 1'h1);
      wg(0, 1'h0);
      chk(n >= 296 && n <= 320, 1'h1);
      chk(gate_on, 6'h00);
      short_on <= 6'h00;
      repeat (20) @(posedge clk);
      chk(gate_on, 6'h00);
      wb(8'h00, 1'h1, 32'h0);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[13:0], 14'h0101);
      wb(8'h18, 1'h1, 32'h00000101);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[13:0], 14'h0000);
      short_on <= 6'h01;
      wb(8'h04, 1'h1, 32'h00050000);
      wb(8'h00, 1'h1, 32'h00000085);
      wg(0, 1'h1);
      wg(0, 1'h0);
      repeat (3) @(posedge clk);
      chk(gate_on, 6'h20);
      short_on <= 6'h00;
      wb(8'h04, 1'h1, 32'h0);
      wb(8'h18, 1'h1, 32'h00000101);
      done_t(5);
      wb(8'h08, 1'h1, 32'h000005A0);
      gnd_short <= 1'h1;
      wb(8'h00, 1'h1, 32'h00090001);
      repeat (2) @(posedge clk);
      chk(phase1_test_current_enable, 1'h1);
      chk(ds_current_enable, 6'h08);
      chk(drain_source_threshold, 3'h5);
      chk(pump_undervolt_threshold, 4'h5);
      repeat (200) @(posedge clk);
      wb(8'h18, 1'h1, 32'h00000001);
      repeat (3) @(posedge clk);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[0], 1'h1);
      gnd_short <= 1'h0;
      repeat (5) @(posedge clk);
      wb(8'h18, 1'h1, 32'h00000001);
      wb(8'h1C, 1'h0, 32'h0);
      chk(q[0], 1'h0);
      wb(8'h00, 1'h1, 32'h0);
      done_t(6);
      wb(8'h0C, 1'h1, 32'h00004800);
      pmeas(4, 8);
      wb(8'h0C, 1'h1, 32'h00014800);
      pmeas(8, 16);
      done_t(7);
      wrap_up();
   end
endmodule

// *** verilog/hbg_bridge_ctrl.sv ***
/*
 hbg_bridge_ctrl: control logic of a three-phase half-bridge gate driver with
 wishbone register access, pwm routing, dead time, slew shaping, charge-pump
 clock dithering and drain-source protection.
 Assumes all inputs synchronous to clk; drivers 0..2 low side, 3..5 high side.
*/
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
// Overview of operation
// - each gate follows its software on bit or the pwm unit, per mode.
// - all protections stay active while the pwm unit drives the gates.
// - turn-on and turn-off each have their own slew shaping.
// - the sequencer walks four current steps in order, each timed.
// - a step has a 5-bit level and 3-bit duration of 50 ns counts.
// - pwm takes over only when all six pwm select bits are one.
// - low sides take complementary compare outputs, high sides the direct ones.
// - one disable bit in the third control register bypasses dead time.
// - dead time is 0.2 us doubled per multiplier and select count.
// - dead time counts module clock cycles, exact at 20 MHz only.
// - dead time only lengthens short gaps, longer gaps pass untouched.
// - pump undervoltage switches all drivers off; threshold is programmable.
// - pump clock comes from system or low-power clock through a divider.
// - pump divider dithers between {base,lower} and {base,upper}.
// - drain-source overvoltage while on shuts all drivers and flags that driver.
// - with local shutdown set, only the faulty driver is turned off.
// - comparator results are filtered, filter time per side group.
// - comparator results are ignored for a blank time after switching.
// - with all drivers off, phase 1 high test current feeds the node.
// - after settling, the low-side status flag shows a low-side short.
// - drain-source flags clear only by writing the clear register.
`timescale 1ns/1ps
`include "hbg_defines.svh"

module hbg_bridge_ctrl #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [2:0] compare_out_ch,
   input wire logic [2:0] compare_out_n_ch,
   input wire logic low_power_clock,
   input wire logic [5:0] ds_cmp,
   input wire logic pump_uv_cmp,
   output logic [5:0] gate_on,
   output logic [5:0] gate_charging,
   output logic [29:0] gate_current,
   output logic pump_clk,
   output logic [2:0] drain_source_threshold,
   output logic [3:0] pump_undervolt_threshold,
   output logic [5:0] ds_current_enable,
   output logic phase1_test_current_enable
);

   hbg_pkg::hbg_state_t s_ff;
   hbg_pkg::hbg_state_t nxt_s;

   logic [5:0][4:0] cur_w;
   logic [5:0] chg_w;

   // {word b, lane} of each driver's byte in the phase registers
   function automatic logic [2:0] drv_slot(input int i);
      case (i)
         0: drv_slot = 3'h0;
         1: drv_slot = 3'h1;
         2: drv_slot = 3'h4;
         3: drv_slot = 3'h2;
         4: drv_slot = 3'h3;
         default: drv_slot = 3'h6;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] sel, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      merge = r & mask;
   endfunction

   always_comb begin
      logic req_take;
      logic wr;
      logic [5:0] adr_w;
      logic [31:0] rd;
      logic pwm_mode;
      logic [5:0] pwm_src;
      logic [5:0] req;
      logic [8:0] tccp;
      logic [9:0] filt_len;
      logic [9:0] blank_len;
      logic [5:0] filtered;
      logic [5:0] oc_det;
      logic [5:0] kill;
      logic [5:0] clr_ds;
      logic [5:0] clr_oc;
      logic clr_uv;
      logic [2:0] slot;
      logic [7:0] byte_v;
      logic [11:0] upper;
      logic [11:0] lower;
      logic tick;
      int o;
      req_take = 1'b0;
      wr = 1'b0;
      adr_w = 6'h00;
      rd = 32'h00000000;
      pwm_mode = 1'b0;
      pwm_src = 6'h00;
      req = 6'h00;
      tccp = 9'h000;
      filt_len = 10'h000;
      blank_len = 10'h000;
      filtered = 6'h00;
      oc_det = 6'h00;
      kill = 6'h00;
      clr_ds = 6'h00;
      clr_oc = 6'h00;
      clr_uv = 1'b0;
      slot = 3'h0;
      byte_v = 8'h00;
      upper = 12'h000;
      lower = 12'h000;
      tick = 1'b0;
      o = 0;
      nxt_s = s_ff;

      // bus: ack one cycle after the request, write at the acked edge
      req_take = wb_cyc_i && wb_stb_i && !s_ff.ack;
      wr = wb_cyc_i && wb_stb_i && wb_we_i && s_ff.ack;
      adr_w = wb_adr_i[7:2];
      nxt_s.ack = req_take;

      if (wr) begin
         for (int i = 0; i < 6; i++) begin
            slot = drv_slot(i);
            if (adr_w == (slot[2] ? `HBG_OFF_PHASE_B : `HBG_OFF_PHASE_A) >> 2 &&
                wb_sel_i[slot[1:0]]) begin
               byte_v = wb_dat_i[{slot[1:0], 3'h0} +: 8];
               nxt_s.en[i] = byte_v[`HBG_BIT_EN];
               nxt_s.pwm_sel[i] = byte_v[`HBG_BIT_PWM];
               nxt_s.on[i] = byte_v[`HBG_BIT_ON];
               nxt_s.dcs_en[i] = byte_v[`HBG_BIT_DCS];
               nxt_s.local_sd[i] = byte_v[`HBG_BIT_LOCSD];
            end
         end
         if (adr_w == `HBG_OFF_BRIDGE_C >> 2) begin
            nxt_s.ctrl_c = merge(s_ff.ctrl_c, wb_dat_i, wb_sel_i, `HBG_C_MASK);
         end
         if (adr_w == `HBG_OFF_PUMP >> 2) begin
            nxt_s.pump_cfg = merge(s_ff.pump_cfg, wb_dat_i, wb_sel_i, `HBG_P_MASK);
         end
         if (adr_w == `HBG_OFF_SLEW_ON >> 2) begin
            nxt_s.slew_on = merge(s_ff.slew_on, wb_dat_i, wb_sel_i, 32'hFFFFFFFF);
         end
         if (adr_w == `HBG_OFF_SLEW_OFF >> 2) begin
            nxt_s.slew_off = merge(s_ff.slew_off, wb_dat_i, wb_sel_i, 32'hFFFFFFFF);
         end
         if (adr_w == `HBG_OFF_CLEAR >> 2) begin
            // write-one-to-clear, lanes gated by byte enables
            clr_ds = wb_sel_i[0] ? wb_dat_i[`HBG_CLR_DS +: 6] : 6'h00;
            clr_oc = wb_sel_i[1] ? wb_dat_i[`HBG_CLR_OC +: 6] : 6'h00;
            clr_uv = wb_sel_i[2] && wb_dat_i[`HBG_CLR_UV];
         end
      end

      // gate request source
      pwm_mode = &s_ff.pwm_sel;
      pwm_src = {compare_out_ch, compare_out_n_ch};
      for (int i = 0; i < 6; i++) begin
         // protections gate the request in either mode
         req[i] = s_ff.en[i] && !pump_uv_cmp &&
                  (pwm_mode ? pwm_src[i] : s_ff.on[i]);
      end

      // dead time in module clock cycles
      tccp = 9'(`HBG_CCP_BASE_CYC) <<
             (3'(s_ff.ctrl_c[`HBG_C_MUL +: 2]) + 3'(s_ff.ctrl_c[`HBG_C_TIMSEL +: 2]));
      for (int i = 0; i < 6; i++) begin
         o = (i < 3) ? i + 3 : i - 3;
         // unless dead time is disabled, a gate turns on only after the partner has been off long enough
         nxt_s.gate[i] = req[i] && (s_ff.ctrl_c[`HBG_C_CCP_DIS] ||
                         (!req[o] && !s_ff.gate[o] && s_ff.since_off[o] >= tccp));
         if (s_ff.gate[i]) begin
            nxt_s.since_off[i] = 9'h000;
         end else if (s_ff.since_off[i] != 9'h1FF) begin
            nxt_s.since_off[i] = s_ff.since_off[i] + 9'h001;
         end
      end

      // drain-source monitor: blank after switching, then filter
      for (int i = 0; i < 6; i++) begin
         filt_len = 10'(`HBG_DS_FILT_BASE_CYC) <<
                    (i < 3 ? s_ff.ctrl_c[`HBG_C_LSFILT +: 2] : s_ff.ctrl_c[`HBG_C_HSFILT +: 2]);
         blank_len = 10'(`HBG_DS_BLANK_BASE_CYC) << s_ff.ctrl_c[`HBG_C_BLANK +: 2];
         if (nxt_s.gate[i] != s_ff.gate[i]) begin
            nxt_s.blank_cnt[i] = blank_len;
         end else if (s_ff.blank_cnt[i] != 10'h000) begin
            nxt_s.blank_cnt[i] = s_ff.blank_cnt[i] - 10'h001;
         end
         if (ds_cmp[i] && s_ff.blank_cnt[i] == 10'h000) begin
            if (s_ff.filt_cnt[i] != 10'h3FF) begin
               nxt_s.filt_cnt[i] = s_ff.filt_cnt[i] + 10'h001;
            end
         end else begin
            nxt_s.filt_cnt[i] = 10'h000;
         end
         filtered[i] = ds_cmp[i] && s_ff.blank_cnt[i] == 10'h000 &&
                       s_ff.filt_cnt[i] >= filt_len;
         oc_det[i] = filtered[i] && s_ff.gate[i];
      end

      // shutdown: global unless local shutdown selected; hw wins over writes
      for (int i = 0; i < 6; i++) begin
         kill[i] = pump_uv_cmp || oc_det[i] ||
                   (|(oc_det & ~s_ff.local_sd));
      end
      nxt_s.en = nxt_s.en & ~kill;
      for (int i = 0; i < 6; i++) begin
         if (kill[i]) begin
            nxt_s.gate[i] = 1'b0;
         end
      end
      // set beats clear on every sticky flag
      nxt_s.ds_sts = (s_ff.ds_sts & ~clr_ds) | filtered;
      nxt_s.oc_sts = (s_ff.oc_sts & ~clr_oc) | oc_det;
      nxt_s.uv_sts = (s_ff.uv_sts && !clr_uv) || pump_uv_cmp;

      // charge-pump clock: divide and sweep the divider between bounds
      nxt_s.lp_prev = low_power_clock;
      tick = s_ff.pump_cfg[`HBG_P_SRC] ? (low_power_clock && !s_ff.lp_prev) : 1'b1;
      upper = {s_ff.pump_cfg[`HBG_P_BASE +: 8], s_ff.pump_cfg[`HBG_P_UPPER +: 4]};
      lower = {s_ff.pump_cfg[`HBG_P_BASE +: 8], s_ff.pump_cfg[`HBG_P_LOWER +: 4]};
      if (tick) begin
         if (s_ff.pump_cnt + 12'h001 >= s_ff.pump_div) begin
            nxt_s.pump_cnt = 12'h000;
            nxt_s.pump_clk = !s_ff.pump_clk;
            if (s_ff.pump_clk) begin
               // one divider step per full pump period
               if (s_ff.pump_div < lower || s_ff.pump_div > upper || lower >= upper) begin
                  nxt_s.pump_div = lower;
                  nxt_s.pump_up = 1'b1;
               end else if (s_ff.pump_up) begin
                  nxt_s.pump_div = s_ff.pump_div + 12'h001;
                  nxt_s.pump_up = (s_ff.pump_div + 12'h001) < upper;
               end else begin
                  nxt_s.pump_div = s_ff.pump_div - 12'h001;
                  nxt_s.pump_up = (s_ff.pump_div - 12'h001) <= lower;
               end
            end
         end else begin
            nxt_s.pump_cnt = s_ff.pump_cnt + 12'h001;
         end
      end

      // read data, captured with the ack
      for (int i = 0; i < 6; i++) begin
         slot = drv_slot(i);
         byte_v = 8'h00;
         byte_v[`HBG_BIT_EN] = s_ff.en[i];
         byte_v[`HBG_BIT_PWM] = s_ff.pwm_sel[i];
         byte_v[`HBG_BIT_ON] = s_ff.on[i];
         byte_v[`HBG_BIT_DCS] = s_ff.dcs_en[i];
         byte_v[`HBG_BIT_DS_STS] = s_ff.ds_sts[i];
         byte_v[`HBG_BIT_OC_STS] = s_ff.oc_sts[i];
         byte_v[`HBG_BIT_LOCSD] = s_ff.local_sd[i];
         if (adr_w == (slot[2] ? `HBG_OFF_PHASE_B : `HBG_OFF_PHASE_A) >> 2) begin
            rd[{slot[1:0], 3'h0} +: 8] = byte_v;
         end
      end
      if (adr_w == `HBG_OFF_BRIDGE_C >> 2) begin
         rd = s_ff.ctrl_c;
      end
      if (adr_w == `HBG_OFF_PUMP >> 2) begin
         rd = s_ff.pump_cfg;
      end
      if (adr_w == `HBG_OFF_SLEW_ON >> 2) begin
         rd = s_ff.slew_on;
      end
      if (adr_w == `HBG_OFF_SLEW_OFF >> 2) begin
         rd = s_ff.slew_off;
      end
      if (adr_w == `HBG_OFF_STATUS >> 2) begin
         rd[`HBG_CLR_DS +: 6] = s_ff.ds_sts;
         rd[`HBG_CLR_OC +: 6] = s_ff.oc_sts;
         rd[`HBG_ST_UV] = s_ff.uv_sts;
         rd[`HBG_ST_PWM] = pwm_mode;
         rd[`HBG_ST_GATE +: 6] = s_ff.gate;
      end
      if (req_take && !wb_we_i) begin
         nxt_s.rdata = rd;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_ff <= '0;
         s_ff.ctrl_c <= `HBG_C_RESET;
         s_ff.pump_cfg <= `HBG_P_RESET;
         s_ff.slew_on <= `HBG_SLEW_RESET;
         s_ff.slew_off <= `HBG_SLEW_RESET;
         s_ff.since_off <= '1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_slew
         hbg_slew_seq u_seq (
            .clk(clk),
            .rst_b(rst_b),
            .gate(s_ff.gate[g]),
            .cfg_on(s_ff.slew_on),
            .cfg_off(s_ff.slew_off),
            .current(cur_w[g]),
            .charging(chg_w[g])
         );
         assign gate_current[g*5 +: 5] = cur_w[g];
      end
   endgenerate

   assign wb_ack_o = s_ff.ack;
   assign wb_dat_o = s_ff.rdata;
   assign gate_on = s_ff.gate;
   assign gate_charging = chg_w;
   assign pump_clk = s_ff.pump_clk;
   assign drain_source_threshold = s_ff.ctrl_c[`HBG_C_DSTH +: 3];
   assign pump_undervolt_threshold = s_ff.ctrl_c[`HBG_C_UVTH +: 4];
   assign ds_current_enable = s_ff.dcs_en;
   // test current source sits on the phase 1 switch node
   assign phase1_test_current_enable = s_ff.dcs_en[3];

endmodule

// *** verilog/hbg_defines.svh ***
/*
 hbg_defines.svh: register offsets, field positions, reset values and timing
 counts of the half-bridge gate driver control block.
 Assumes a 100 MHz clk; included by its bare name.
*/
`ifndef HBG_DEFINES_SVH
`define HBG_DEFINES_SVH

// byte offsets on the wishbone bus
`define HBG_OFF_PHASE_A 8'h00
`define HBG_OFF_PHASE_B 8'h04
`define HBG_OFF_BRIDGE_C 8'h08
`define HBG_OFF_PUMP 8'h0C
`define HBG_OFF_SLEW_ON 8'h10
`define HBG_OFF_SLEW_OFF 8'h14
`define HBG_OFF_CLEAR 8'h18
`define HBG_OFF_STATUS 8'h1C

// per-driver byte inside the phase registers
`define HBG_BIT_EN 0
`define HBG_BIT_PWM 1
`define HBG_BIT_ON 2
`define HBG_BIT_DCS 3
`define HBG_BIT_DS_STS 4
`define HBG_BIT_OC_STS 6
`define HBG_BIT_LOCSD 7

// bridge_ctrl_c fields
`define HBG_C_CCP_DIS 0
`define HBG_C_TIMSEL 1
`define HBG_C_MUL 3
`define HBG_C_DSTH 5
`define HBG_C_UVTH 8
`define HBG_C_HSFILT 12
`define HBG_C_LSFILT 14
`define HBG_C_BLANK 16
`define HBG_C_MASK 32'h0003FFFF
`define HBG_C_RESET 32'h00000000

// pump configuration fields
`define HBG_P_BASE 0
`define HBG_P_UPPER 8
`define HBG_P_LOWER 12
`define HBG_P_SRC 16
`define HBG_P_MASK 32'h0001FFFF
`define HBG_P_RESET 32'h00000F10
`define HBG_SLEW_RESET 32'h00000000

// clear register and status register fields
`define HBG_CLR_DS 0
`define HBG_CLR_OC 8
`define HBG_CLR_UV 16
`define HBG_ST_UV 16
`define HBG_ST_PWM 17
`define HBG_ST_GATE 24

// timing
`define HBG_CLK_MHZ 100
`define HBG_SLEW_STEP_NS 50
`define HBG_SLEW_STEP_CYC ((`HBG_SLEW_STEP_NS * `HBG_CLK_MHZ + 999) / 1000)
`define HBG_MODCLK_REF_MHZ 20
`define HBG_CCP_BASE_NS 200
`define HBG_CCP_BASE_CYC ((`HBG_CCP_BASE_NS * `HBG_MODCLK_REF_MHZ) / 1000)
`define HBG_DS_FILT_BASE_NS 500
`define HBG_DS_FILT_BASE_CYC ((`HBG_DS_FILT_BASE_NS * `HBG_CLK_MHZ + 999) / 1000)
`define HBG_DS_BLANK_BASE_NS 1000
`define HBG_DS_BLANK_BASE_CYC ((`HBG_DS_BLANK_BASE_NS * `HBG_CLK_MHZ + 999) / 1000)

`endif

// *** verilog/hbg_pkg.sv ***
/*
 hbg_pkg: state types of the gate driver control block and its slew sequencer.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package hbg_pkg;

   typedef struct packed {
      logic prev;
      logic charging;
      logic done;
      logic [1:0] step;
      logic [5:0] cnt;
      logic [4:0] cur;
   } hbg_slew_t;

   typedef struct packed {
      logic [5:0] en;
      logic [5:0] pwm_sel;
      logic [5:0] on;
      logic [5:0] dcs_en;
      logic [5:0] local_sd;
      logic [5:0] ds_sts;
      logic [5:0] oc_sts;
      logic uv_sts;
      logic [31:0] ctrl_c;
      logic [31:0] pump_cfg;
      logic [31:0] slew_on;
      logic [31:0] slew_off;
      logic [5:0] gate;
      logic [5:0][8:0] since_off;
      logic [5:0][9:0] blank_cnt;
      logic [5:0][9:0] filt_cnt;
      logic lp_prev;
      logic [11:0] pump_cnt;
      logic [11:0] pump_div;
      logic pump_up;
      logic pump_clk;
      logic ack;
      logic [31:0] rdata;
   } hbg_state_t;

endpackage

// *** verilog/hbg_slew_seq.sv ***
/*
 hbg_slew_seq: four-step gate current sequencer for one driver.
 Assumes gate is the registered on/off command of the driver and that the
 step configuration words hold {duration[7:5], level[4:0]} per byte.
*/
`timescale 1ns/1ps
`include "hbg_defines.svh"

module hbg_slew_seq (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic gate,
   input wire logic [31:0] cfg_on,
   input wire logic [31:0] cfg_off,
   output logic [4:0] current,
   output logic charging
);

   hbg_pkg::hbg_slew_t s_ff;
   hbg_pkg::hbg_slew_t nxt_s;

   always_comb begin
      logic [31:0] cfg;
      logic [2:0] dur;
      logic [5:0] len;
      cfg = 32'h00000000;
      dur = 3'h0;
      len = 6'h00;
      nxt_s = s_ff;
      nxt_s.prev = gate;
      if (gate != s_ff.prev) begin
         // every new command starts over at step one
         nxt_s.charging = gate;
         nxt_s.step = 2'h0;
         nxt_s.cnt = 6'h00;
         nxt_s.done = 1'b0;
         cfg = gate ? cfg_on : cfg_off;
         nxt_s.cur = cfg[4:0];
      end else if (!s_ff.done) begin
         cfg = s_ff.charging ? cfg_on : cfg_off;
         dur = cfg[{s_ff.step, 3'h5} +: 3];
         len = 6'(dur) * 6'(`HBG_SLEW_STEP_CYC);
         if (len == 6'h00 || s_ff.cnt + 6'h01 >= len) begin
            nxt_s.cnt = 6'h00;
            if (s_ff.step == 2'h3) begin
               // last level is held until the next command
               nxt_s.done = 1'b1;
            end else begin
               nxt_s.step = s_ff.step + 2'h1;
               nxt_s.cur = cfg[{s_ff.step + 2'h1, 3'h0} +: 5];
            end
         end else begin
            nxt_s.cnt = s_ff.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign current = s_ff.cur;
   assign charging = s_ff.charging;

endmodule
